// ### ifag_addr_gen.sv
// effective storage address adder: base + index + displacement
`timescale 1ns/1ps
`default_nettype none
module ifag_addr_gen (
   input  wire ifag_pkg::ifag_gr_t       gr_i,
   input  wire ifag_pkg::ifag_agen_req_s req_i,
   output var  logic [23:0]              eaddr_o
);

   logic [23:0] base_val;
   logic [23:0] index_val;

   // ==========================================================
   // operand selection and sum
   always_comb begin
      // selector zero means no component, whatever register 0 holds
      base_val = (req_i.base_sel == 4'h0) ? 24'h000000
               : gr_i[req_i.base_sel][23:0];
      index_val = (req_i.use_index && req_i.index_sel != 4'h0)
                ? gr_i[req_i.index_sel][23:0] : 24'h000000;
      // carry out of bit 23 drops
      eaddr_o = base_val + index_val
              + {12'h000, req_i.disp};
   end

endmodule // ifag_addr_gen
`default_nettype wire

// ### ifag_pkg.sv
// constants, types and register map of the instruction format decoder
`default_nettype none
package ifag_pkg;

   // ==========================================================
   // sizes
   localparam int unsigned GR_COUNT        = 16;
   localparam int unsigned GR_WIDTH        = 32;
   localparam int unsigned ADDR_WIDTH      = 24;
   localparam int unsigned DISP_WIDTH      = 12;
   localparam int unsigned OPCODE_SPACE    = 256;
   localparam int unsigned MAX_DEFINED_OPS = 112;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFF_GR0     = 8'h00;
   localparam logic [7:0] OFF_IA      = 8'h40;
   localparam logic [7:0] OFF_INSTR   = 8'h44;
   localparam logic [7:0] OFF_STATUS  = 8'h48;
   localparam logic [7:0] OFF_FIELDS  = 8'h4C;
   localparam logic [7:0] OFF_EADDR   = 8'h50;
   localparam logic [7:0] OFF_CTRL    = 8'h54;
   localparam logic [7:0] OFF_DEFMAP0 = 8'h60;

   localparam logic [5:0] IDX_GR0     = OFF_GR0[7:2];
   localparam logic [5:0] IDX_IA      = OFF_IA[7:2];
   localparam logic [5:0] IDX_INSTR   = OFF_INSTR[7:2];
   localparam logic [5:0] IDX_STATUS  = OFF_STATUS[7:2];
   localparam logic [5:0] IDX_FIELDS  = OFF_FIELDS[7:2];
   localparam logic [5:0] IDX_EADDR   = OFF_EADDR[7:2];
   localparam logic [5:0] IDX_CTRL    = OFF_CTRL[7:2];
   localparam logic [5:0] IDX_DEFMAP0 = OFF_DEFMAP0[7:2];

   // ==========================================================
   // field positions
   localparam int unsigned ST_ALIGN_BIT   = 14;
   localparam int unsigned ST_REFUSED_BIT = 15;
   localparam int unsigned CTRL_IGN_HI    = 0;
   localparam int unsigned CTRL_IGN_LO    = 1;
   localparam int unsigned SI_SEL_BIT     = 4;
   localparam logic [2:0]  HSIZE_WORD     = 3'h2;

   // ==========================================================
   // encodings and reset values
   localparam logic [1:0] FMT_RR    = 2'h0;
   localparam logic [1:0] FMT_RX    = 2'h1;
   localparam logic [1:0] FMT_RS_SI = 2'h2;
   localparam logic [1:0] FMT_NONE  = 2'h3;
   localparam logic [1:0] LEN_NONE  = 2'h0;
   localparam logic [1:0] LEN_ONE   = 2'h1;
   localparam logic [1:0] LEN_TWO   = 2'h2;
   localparam logic       HREADY_RESET = 1'b1;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_DECODE = 2'h1,
      ST_ADDR   = 2'h3
   } ifag_state_e;

   typedef logic [GR_COUNT-1:0][GR_WIDTH-1:0] ifag_gr_t;
   typedef logic [7:0][31:0]                  ifag_defmap_t;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [1:0]  fmt;
      logic [1:0]  len_hw;
      logic        unsup;
      logic        undef;
      logic        is_si;
      logic        use_index;
      logic [3:0]  first_operand_reg_field;
      logic [3:0]  second_operand_reg_field;
      logic [7:0]  immediate_byte_field;
      logic [3:0]  second_base_field;
      logic [11:0] second_offset_field;
   } ifag_dec_s;

   typedef struct packed {
      logic [3:0]  base_sel;
      logic [3:0]  index_sel;
      logic        use_index;
      logic [11:0] disp;
   } ifag_agen_req_s;

   typedef struct packed {
      ifag_gr_t     gr;
      ifag_defmap_t defmap;
      logic [8:0]   defcnt;
      logic [23:0]  ia;
      logic [31:0]  instr;
      ifag_state_e  st;
      ifag_dec_s    dec;
      logic [23:0]  ea;
      logic         ea_valid;
      logic [1:0]   ctrl;
      logic         align_err;
      logic         map_refused;
      logic         wr_pend;
      logic         rd_pend;
      logic [5:0]   ph_idx;
      logic         ph_hit;
      logic         hreadyout;
      logic         hresp;
      logic [31:0]  hrdata;
      logic [23:0]  stor_addr;
      logic         stor_req;
   } ifag_top_s;

endpackage
`default_nettype wire

// ### ifag_stor_model.sv
// storage address port model: counts requests and keeps the last address
`timescale 1ns/1ps
`default_nettype none
module ifag_stor_model (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        stor_req_i,
   input  wire logic [23:0] stor_addr_i,
   output var  logic [7:0]  pulses_o,
   output var  logic [23:0] last_addr_o
);
   // ==========================================================
   // capture
   // storage accepts every request at once, address taken with the pulse
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulses_o    <= 8'h00;
         last_addr_o <= 24'h000000;
      end else if (stor_req_i) begin
         pulses_o    <= pulses_o + 8'h01;
         last_addr_o <= stor_addr_i;
      end
   end
endmodule // ifag_stor_model
`default_nettype wire

// ### ifag_tb.sv
// self-checking bench of the instruction format decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        ref_clk;
   logic        rst_n;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [23:0] stor_addr;
   logic        stor_req;
   logic [23:0] fetch_addr;
   logic [7:0]  pulses;
   logic [23:0] last_addr;
   int          fails;
   int          samples_checked;
   int          waits;

   ifag_top i_dut (
      .ref_clk_i    (ref_clk),
      .rst_n_i      (rst_n),
      .hsel_i       (1'b1),
      .haddr_i      (haddr),
      .htrans_i     (htrans),
      .hwrite_i     (hwrite),
      .hsize_i      (ifag_pkg::HSIZE_WORD),
      .hwdata_i     (hwdata),
      .hready_i     (hreadyout),
      .hrdata_o     (hrdata),
      .hreadyout_o  (hreadyout),
      .hresp_o      (hresp),
      .stor_addr_o  (stor_addr),
      .stor_req_o   (stor_req),
      .fetch_addr_o (fetch_addr)
   );

   ifag_stor_model i_stor (
      .clk_i       (ref_clk),
      .rst_n_i     (rst_n),
      .stor_req_i  (stor_req),
      .stor_addr_i (stor_addr),
      .pulses_o    (pulses),
      .last_addr_o (last_addr)
   );

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // report
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // ==========================================================
   // bus cycles
   // hready is looked at while settled, then the edge is taken
   task automatic wait_rdy(output logic [31:0] q);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            fails++;
            tally_and_finish();
         end
         @(negedge ref_clk);
      end
      waits = n;
      q = hrdata;
      @(posedge ref_clk);
   endtask

   task automatic bus(input logic w, input logic [31:0] a, d,
                      output logic [31:0] q);
      logic [31:0] dummy;
      @(posedge ref_clk);
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      wait_rdy(dummy);
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy(q);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, {24'h000000, a}, d, q);
   endtask

   task automatic rdc(input string name, input logic [7:0] a,
                      input logic [31:0] mask, exp);
      logic [31:0] q;
      bus(1'b0, {24'h000000, a}, 32'h00000000, q);
      chk(name, q & mask, exp);
      // read answer: hreadyout low for exactly one data-phase cycle
      chk("read_wait", waits, 32'h00000001);
   endtask

   // ==========================================================
   // one instruction through decode
   task automatic do_instr(input logic [1:0] ctrl, input logic [31:0] ins,
                           input logic [31:0] stat, input logic [23:0] fd,
                           input logic pulse, input logic [23:0] ea,
                           input logic [31:0] fld, fmask);
      logic [23:0] fa0;
      logic [7:0]  n0;
      wr(ifag_pkg::OFF_CTRL, {30'h00000000, ctrl});
      fa0 = fetch_addr;
      n0  = pulses;
      wr(ifag_pkg::OFF_INSTR, ins);
      repeat (3) @(posedge ref_clk);
      rdc("status", ifag_pkg::OFF_STATUS, 32'h00003FFF, stat);
      rdc("fields", ifag_pkg::OFF_FIELDS, fmask, fld);
      chk("fetch", {8'h00, fetch_addr}, {8'h00, fa0 + fd});
      chk("requests", {24'h000000, pulses - n0}, {31'h0, pulse});
      if (pulse) begin
         chk("stor_addr", {8'h00, last_addr}, {8'h00, ea});
         rdc("eaddr", ifag_pkg::OFF_EADDR, 32'h01FFFFFF,
             {8'h01, ea});
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      fails = 0;
      samples_checked = 0;
      rst_n  = 1'b0;
      haddr  = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h00000000;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rdc("status_rst", ifag_pkg::OFF_STATUS, 32'hFFFFFFFF, 32'h00000000);
      chk("fetch_rst", {8'h00, fetch_addr}, 32'h00000000);
      chk("hresp", {31'h0, hresp}, 32'h00000000);
      wr(8'h00, 32'h00000123);
      wr(8'h38, 32'hFF000F00);
      wr(8'h34, 32'h00FFFFFF);
      wr(8'h28, 32'h00000010);
      rdc("gr14", 8'h38, 32'hFFFFFFFF, 32'hFF000F00);
      rdc("gr13", 8'h34, 32'hFFFFFFFF, 32'h00FFFFFF);
      rdc("unmapped", 8'h58, 32'hFFFFFFFF, 32'h00000000);
      // opcodes 00-1F, 40-5F, 80-9F defined: 96 codes
      wr(8'h60, 32'hFFFFFFFF);
      wr(8'h68, 32'hFFFFFFFF);
      wr(8'h70, 32'hFFFFFFFF);
      rdc("defcount", ifag_pkg::OFF_STATUS, 32'h07FC0000,
          32'h01800000);
      // another 32 would exceed 112
      wr(8'h78, 32'hFFFFFFFF);
      rdc("refused", ifag_pkg::OFF_STATUS, 32'h07FC8000,
          32'h01808000);
      rdc("map6", 8'h78, 32'hFFFFFFFF, 32'h00000000);
      wr(ifag_pkg::OFF_STATUS, 32'h00008000);
      wr(ifag_pkg::OFF_IA, 32'h00000101);
      rdc("ia", ifag_pkg::OFF_IA, 32'h00FFFFFF, 32'h00000100);
      rdc("align", ifag_pkg::OFF_STATUS, 32'h0000C000,
          32'h00004000);
      chk("fetch_ia", {8'h00, fetch_addr}, 32'h00000100);
      wr(ifag_pkg::OFF_STATUS, 32'h00004000);
      rdc("cleared", ifag_pkg::OFF_STATUS, 32'h0000C000, 32'h00000000);
      // ctrl ins stat delta pulse ea fields mask
      do_instr(2'h0, 32'h1A790000, 32'h0000041A, 24'h000002, 1'b0,
               24'h000000, 32'h00000097, 32'h000000FF);
      do_instr(2'h0, 32'h503AE12C, 32'h00000950, 24'h000004, 1'b1,
               24'h00103C, 32'h12CE00A3, 32'hFFFF00FF);
      do_instr(2'h0, 32'h5030DFFF, 32'h00000950, 24'h000004, 1'b1,
               24'h000FFE, 32'hFFFD0003, 32'hFFFF00FF);
      do_instr(2'h0, 32'h883A0456, 32'h00000A88, 24'h000004, 1'b1,
               24'h000456, 32'h456000A3, 32'hFFFF00FF);
      do_instr(2'h0, 32'h92ABE010, 32'h00000A92, 24'h000004, 1'b1,
               24'h000F10, 32'h010EAB00, 32'hFFFFFFFF);
      do_instr(2'h0, 32'h30000000, 32'h00002430, 24'h000002, 1'b0,
               24'h000000, 32'h00000000, 32'h00000000);
      do_instr(2'h0, 32'hC5123456, 32'h000033C5, 24'h000000, 1'b0,
               24'h000000, 32'h00000000, 32'h00000000);
      do_instr(2'h1, 32'h1A790000, 32'h0000041A, 24'h000002, 1'b0,
               24'h000000, 32'h00000090, 32'h000000FF);
      do_instr(2'h2, 32'h503AE12C, 32'h00000950, 24'h000004, 1'b1,
               24'h00102C, 32'h12CE0003, 32'hFFFF00FF);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire

// ### ifag_top.sv
// instruction format decoder, register file and address generator
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ifag_top (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output var  logic [31:0] hrdata_o,
   output var  logic        hreadyout_o,
   output var  logic        hresp_o,
   output var  logic [23:0] stor_addr_o,
   output var  logic        stor_req_o,
   output var  logic [23:0] fetch_addr_o
);

   ifag_pkg::ifag_top_s      r;
   ifag_pkg::ifag_top_s      n;
   ifag_pkg::ifag_agen_req_s agen_req;
   logic [23:0]              ea_w;
   logic [31:0]              rdata;
   logic [31:0]              status_w;
   logic [31:0]              fields_w;

   function automatic logic [5:0] popcnt(input logic [31:0] w);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 0; i < 32; i++) begin
         c = c + {5'h00, w[i]};
      end
      return c;
   endfunction

   // ==========================================================
   // address generator
   always_comb begin
      agen_req.base_sel  = r.dec.second_base_field;
      agen_req.index_sel = r.dec.second_operand_reg_field;
      agen_req.use_index = r.dec.use_index;
      agen_req.disp      = r.dec.second_offset_field;
   end

   ifag_addr_gen u_agen (
      .gr_i    (r.gr),
      .req_i   (agen_req),
      .eaddr_o (ea_w)
   );

   // ==========================================================
   // read view
   always_comb begin
      status_w = {5'h00, r.defcnt, r.ea_valid, (r.st != ifag_pkg::ST_IDLE),
                  r.map_refused, r.align_err, r.dec.undef, r.dec.unsup,
                  r.dec.len_hw, r.dec.fmt, r.dec.opcode};
      fields_w = {r.dec.second_offset_field, r.dec.second_base_field,
                  r.dec.immediate_byte_field,
                  r.dec.second_operand_reg_field,
                  r.dec.first_operand_reg_field};
      rdata = 32'h00000000;
      if (r.ph_hit) begin
         if (r.ph_idx < ifag_pkg::IDX_IA) begin
            rdata = r.gr[r.ph_idx[3:0]];
         end else if (r.ph_idx[5:3] == ifag_pkg::IDX_DEFMAP0[5:3]) begin
            rdata = r.defmap[r.ph_idx[2:0]];
         end else begin
            case (r.ph_idx)
               ifag_pkg::IDX_IA:     rdata = {8'h00, r.ia};
               ifag_pkg::IDX_INSTR:  rdata = r.instr;
               ifag_pkg::IDX_STATUS: rdata = status_w;
               ifag_pkg::IDX_FIELDS: rdata = fields_w;
               ifag_pkg::IDX_EADDR:  rdata = {7'h00, r.ea_valid, r.ea};
               ifag_pkg::IDX_CTRL:   rdata = {30'h00000000, r.ctrl};
               default:              rdata = 32'h00000000;
            endcase
         end
      end
   end

   // ==========================================================
   // next state
   always_comb begin
      logic [7:0]        op;
      ifag_pkg::ifag_dec_s d;
      logic [2:0]        k;
      logic [9:0]        cnt_tmp;
      op      = r.instr[31:24];
      d       = '0;
      k       = r.ph_idx[2:0];
      cnt_tmp = 10'h000;
      n          = r;
      n.stor_req = 1'b0;

      // decode and address sequence
      unique case (r.st)
         ifag_pkg::ST_IDLE: begin
         end
         ifag_pkg::ST_DECODE: begin
            d.opcode = op;
            d.fmt    = op[7:6];
            unique case (op[7:6])
               ifag_pkg::FMT_RR:    d.len_hw = ifag_pkg::LEN_ONE;
               ifag_pkg::FMT_RX:    d.len_hw = ifag_pkg::LEN_TWO;
               ifag_pkg::FMT_RS_SI: d.len_hw = ifag_pkg::LEN_TWO;
               ifag_pkg::FMT_NONE: begin
                  d.len_hw = ifag_pkg::LEN_NONE;
                  d.unsup  = 1'b1;
               end
            endcase
            d.undef = !r.defmap[op[7:5]][op[4:0]];
            if (!d.unsup) begin
               d.is_si = (op[7:6] == ifag_pkg::FMT_RS_SI)
                       && op[ifag_pkg::SI_SEL_BIT];
               d.use_index = (op[7:6] == ifag_pkg::FMT_RX);
               if (d.is_si) begin
                  d.immediate_byte_field = r.instr[23:16];
               end else begin
                  d.first_operand_reg_field  = r.instr[23:20];
                  d.second_operand_reg_field = r.instr[19:16];
               end
               if (r.ctrl[ifag_pkg::CTRL_IGN_HI]) begin
                  d.first_operand_reg_field = 4'h0;
               end
               if (r.ctrl[ifag_pkg::CTRL_IGN_LO]) begin
                  d.second_operand_reg_field = 4'h0;
                  d.use_index = 1'b0;
               end
               if (d.len_hw == ifag_pkg::LEN_TWO) begin
                  d.second_base_field   = r.instr[15:12];
                  d.second_offset_field = r.instr[11:0];
               end
            end
            n.dec = d;
            n.st  = ifag_pkg::ST_ADDR;
         end
         ifag_pkg::ST_ADDR: begin
            n.st = ifag_pkg::ST_IDLE;
            // length in bytes is halfwords times two
            n.ia = r.ia + {21'h000000, r.dec.len_hw, 1'b0};
            if (r.dec.len_hw == ifag_pkg::LEN_TWO && !r.dec.undef) begin
               n.ea       = ea_w;
               n.ea_valid = 1'b1;
               n.stor_addr = ea_w;
               n.stor_req = 1'b1;
            end
         end
         default: n.st = ifag_pkg::ST_IDLE;
      endcase

      // bus data phase: read answer, one wait state
      if (r.rd_pend) begin
         n.rd_pend   = 1'b0;
         n.hreadyout = 1'b1;
         n.hrdata    = rdata;
      end

      // bus data phase: write, wins over the sequencer
      if (r.wr_pend) begin
         n.wr_pend = 1'b0;
         if (r.ph_hit) begin
            if (r.ph_idx < ifag_pkg::IDX_IA) begin
               n.gr[r.ph_idx[3:0]] = hwdata_i;
            end else if (r.ph_idx[5:3] == ifag_pkg::IDX_DEFMAP0[5:3]) begin
               cnt_tmp = {1'b0, r.defcnt} - {4'h0, popcnt(r.defmap[k])}
                       + {4'h0, popcnt(hwdata_i)};
               if (cnt_tmp > 10'(ifag_pkg::MAX_DEFINED_OPS)) begin
                  n.map_refused = 1'b1;
               end else begin
                  n.defmap[k] = hwdata_i;
                  n.defcnt    = cnt_tmp[8:0];
               end
            end else begin
               case (r.ph_idx)
                  ifag_pkg::IDX_IA: begin
                     n.ia = {hwdata_i[23:1], 1'b0};
                     if (hwdata_i[0]) begin
                        n.align_err = 1'b1;
                     end
                  end
                  ifag_pkg::IDX_INSTR: begin
                     if (r.st == ifag_pkg::ST_IDLE) begin
                        n.instr    = hwdata_i;
                        n.st       = ifag_pkg::ST_DECODE;
                        n.ea_valid = 1'b0;
                     end
                  end
                  ifag_pkg::IDX_STATUS: begin
                     if (hwdata_i[ifag_pkg::ST_ALIGN_BIT]) begin
                        n.align_err = 1'b0;
                     end
                     if (hwdata_i[ifag_pkg::ST_REFUSED_BIT]) begin
                        n.map_refused = 1'b0;
                     end
                  end
                  ifag_pkg::IDX_CTRL: n.ctrl = hwdata_i[1:0];
                  default: begin
                  end
               endcase
            end
         end
      end

      // bus address phase
      if (hsel_i && htrans_i[1] && hready_i) begin
         n.ph_idx = haddr_i[7:2];
         n.ph_hit = (haddr_i[31:8] == 24'h000000)
                  && (haddr_i[1:0] == 2'h0)
                  && (hsize_i == ifag_pkg::HSIZE_WORD);
         if (hwrite_i) begin
            n.wr_pend = 1'b1;
         end else begin
            n.rd_pend   = 1'b1;
            n.hreadyout = 1'b0;
         end
      end
      n.hresp = 1'b0;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r           <= '0;
         r.hreadyout <= ifag_pkg::HREADY_RESET;
      end else begin
         r <= n;
      end
   end

   // ==========================================================
   // outputs
   assign hrdata_o     = r.hrdata;
   assign hreadyout_o  = r.hreadyout;
   assign hresp_o      = r.hresp;
   assign stor_addr_o  = r.stor_addr;
   assign stor_req_o   = r.stor_req;
   assign fetch_addr_o = r.ia;

   // ==========================================================
   // checks
   logic [23:0] chk_base;
   logic [23:0] chk_index;

   always_comb begin
      chk_base = (r.dec.second_base_field == 4'h0) ? 24'h000000
               : r.gr[r.dec.second_base_field][23:0];
      chk_index = (r.dec.use_index && r.dec.second_operand_reg_field != 4'h0)
                ? r.gr[r.dec.second_operand_reg_field][23:0] : 24'h000000;
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_decode_step;
      r.st == ifag_pkg::ST_DECODE;
   endsequence

   sequence s_addr_step;
      r.st == ifag_pkg::ST_ADDR
         && !(r.wr_pend && r.ph_hit && r.ph_idx == ifag_pkg::IDX_IA);
   endsequence

   a_greg_write: assert property (
      r.wr_pend && r.ph_hit && r.ph_idx < ifag_pkg::IDX_IA
      |=> r.gr[$past(r.ph_idx[3:0])] == $past(hwdata_i))
      else $error("general register write lost");
   a_storage_length: assert property (
      stor_req_o |-> r.dec.len_hw == ifag_pkg::LEN_TWO && !r.dec.unsup)
      else $error("storage reference from short instruction");
   a_ia_aligned: assert property (!fetch_addr_o[0])
      else $error("instruction address odd");
   a_opcode_take: assert property (
      s_decode_step |=> r.dec.opcode == $past(r.instr[31:24]))
      else $error("opcode not first byte");
   a_defined_cap: assert property (
      r.defcnt <= 9'(ifag_pkg::MAX_DEFINED_OPS))
      else $error("too many defined opcodes");
   a_len_format: assert property (
      s_decode_step |=> r.dec.len_hw == (r.dec.fmt == ifag_pkg::FMT_RR
         ? ifag_pkg::LEN_ONE : (r.dec.fmt == ifag_pkg::FMT_NONE
         ? ifag_pkg::LEN_NONE : ifag_pkg::LEN_TWO)))
      else $error("length does not match format bits");
   a_imm_byte: assert property (
      s_decode_step ##1 r.dec.is_si
      |-> r.dec.immediate_byte_field == $past(r.instr[23:16]))
      else $error("immediate byte wrong");
   a_ignore_half: assert property (
      s_decode_step ##0 r.ctrl[ifag_pkg::CTRL_IGN_HI]
      |=> r.dec.first_operand_reg_field == 4'h0)
      else $error("ignored nibble not cleared");
   a_base_parse: assert property (
      s_decode_step ##1 r.dec.len_hw == ifag_pkg::LEN_TWO
      |-> r.dec.second_base_field == $past(r.instr[15:12])
          && r.dec.second_offset_field == $past(r.instr[11:0]))
      else $error("second halfword parsed wrong");
   a_ea_sum: assert property (
      stor_req_o |-> stor_addr_o == 24'(chk_base + chk_index
         + {12'h000, r.dec.second_offset_field}))
      else $error("effective address wrong");
   a_zero_sel: assert property (
      stor_req_o && r.dec.second_base_field == 4'h0 && !r.dec.use_index
      |-> stor_addr_o == {12'h000, r.dec.second_offset_field})
      else $error("zero base not zero");
   a_ia_advance: assert property (
      s_addr_step |=> r.ia == $past(r.ia)
         + {21'h000000, $past(r.dec.len_hw), 1'b0})
      else $error("instruction address not advanced");
   a_unsup_flag: assert property (
      s_decode_step ##0 r.instr[31:30] == 2'h3
      |=> r.dec.unsup && r.dec.len_hw == ifag_pkg::LEN_NONE
          ##1 !stor_req_o)
      else $error("format 11 not flagged");

endmodule // ifag_top
`default_nettype wire
